// ===== logic/jls_sequencer.sv
`timescale 1ns/1ps

module jls_sequencer
  import jls_pkg::*;
#(
  parameter int unsigned MAX_SCAN_CYC = `JLS_MAX_SCAN_CYC
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset,
  // instruction stream
  input  wire jls_instr_s instr,
  input  wire logic       block_mode,
  input  wire logic       scan_start,
  input  wire logic       prog_end,
  // end marker table load
  input  wire logic       mark_clr,
  input  wire jls_mark_s  mark,
  // results
  output jls_res_s        res,
  output jls_flags_s      flags,
  output logic            overrun_err,
  output logic            timer_keep
);

  //////////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic logic jnum_ok(input logic [`JLS_OPND_W-1:0] n);
    jnum_ok = (n <= `JLS_JNUM_MAX);
  endfunction

  function automatic logic [`JLS_NUM_W-1:0] jnum(input logic [`JLS_OPND_W-1:0] n);
    jnum = n[`JLS_NUM_W-1:0];
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // state

  jls_state_s st_r;
  jls_state_s st_nxt;

  logic [`JLS_DEPTH_W-1:0] top;
  logic [`JLS_NUM_W-1:0]   num;
  logic [`JLS_EDGE_W-1:0]  slot;
  logic                    want;
  logic                    edge_now;

  always_comb begin
    st_nxt              = st_r;
    st_nxt.res.valid    = 1'b0;
    st_nxt.res.redirect = 1'b0;
    top      = st_r.depth - `JLS_DEPTH_ONE;
    num      = jnum(instr.operand);
    slot     = instr.operand[`JLS_EDGE_W-1:0];
    want     = 1'b0;
    edge_now = 1'b0;

    if (scan_start) begin
      st_nxt.scan_cnt = '0;
    end else if (!prog_end && !st_r.overrun) begin
      st_nxt.scan_cnt = st_r.scan_cnt + `JLS_SCAN_ONE;
      if (st_r.scan_cnt >= MAX_SCAN_CYC[`JLS_SCAN_W-1:0] - `JLS_SCAN_ONE) begin
        st_nxt.overrun = 1'b1;
      end
    end

    // each scan begins with an empty loop stack and cleared ed_done bits; ed_prev history carries over
    if (scan_start) begin
      st_nxt.ed_done = '0;
      st_nxt.depth   = `JLS_DEPTH_ZERO;
      st_nxt.mode    = JLS_RUN;
    end

    if (mark_clr) begin
      st_nxt.mk_valid = '0;
    end else if (mark.valid) begin
      if (!st_r.mk_valid[mark.num] || mark.addr < st_r.mk_addr[mark.num]) begin
        st_nxt.mk_valid[mark.num] = 1'b1;
        st_nxt.mk_addr[mark.num]  = mark.addr;
      end
    end

    if (instr.valid && !scan_start) begin
      st_nxt.res.valid  = 1'b1;
      st_nxt.res.exec   = 1'b0;
      st_nxt.res.no_operation    = 1'b0;
      st_nxt.res.target = st_r.res.target;

      if (st_r.mode == JLS_NOPREG) begin
        st_nxt.res.no_operation = 1'b1;
        unique case (instr.op)
          JLS_OP_LOOP_START: begin
            if (st_r.nop_kind != JLS_NOP_NJ) begin
              st_nxt.nop_depth = st_r.nop_depth + `JLS_DEPTH_ONE;
            end
          end
          JLS_OP_LOOP_END: begin
            if (st_r.nop_kind != JLS_NOP_NJ) begin
              if (st_r.nop_depth == `JLS_DEPTH_ZERO) begin
                st_nxt.mode = JLS_RUN;
                if (st_r.nop_kind == JLS_NOP_BREAK) begin
                  st_nxt.depth = top;
                end
              end else begin
                st_nxt.nop_depth = st_r.nop_depth - `JLS_DEPTH_ONE;
              end
            end
          end
          JLS_OP_NOP_STYLE_JUMP_END: begin
            if (st_r.nop_kind == JLS_NOP_NJ && num == st_r.nop_num && jnum_ok(instr.operand)) begin
              st_nxt.mode = JLS_RUN;
            end
          end
          default: begin
          end
        endcase
      end else begin
        st_nxt.res.exec = 1'b1;
        unique case (instr.op)
          JLS_OP_JUMP_ON_FALSE,
          JLS_OP_JUMP_ON_TRUE: begin
            want = (instr.op == JLS_OP_JUMP_ON_FALSE) ? (!instr.cond || block_mode)
                                                      : instr.cond;
            if (!jnum_ok(instr.operand)) begin
              st_nxt.flags.error_flag = 1'b1;
            end else if (!st_r.mk_valid[num]) begin
              st_nxt.flags.error_flag = 1'b1;
            end else begin
              st_nxt.flags.error_flag = 1'b0;
              if (want) begin
                st_nxt.res.redirect = 1'b1;
                st_nxt.res.target   = st_r.mk_addr[num];
              end
            end
          end
          JLS_OP_JUMP_END_MARKER: begin
            st_nxt.flags = st_r.flags;
          end
          JLS_OP_NOP_STYLE_JUMP: begin
            if (!jnum_ok(instr.operand)) begin
              st_nxt.flags.error_flag = 1'b1;
            end else begin
              st_nxt.flags.error_flag = 1'b0;
              if (!instr.cond) begin
                st_nxt.mode     = JLS_NOPREG;
                st_nxt.nop_kind = JLS_NOP_NJ;
                st_nxt.nop_num  = num;
              end
            end
          end
          JLS_OP_LOOP_START: begin
            st_nxt.flags.equals_flag   = 1'b0;
            st_nxt.flags.negative_flag = 1'b0;
            st_nxt.flags.error_flag    = (st_r.depth == `JLS_DEPTH_FULL);
            if (st_r.depth == `JLS_DEPTH_FULL || instr.operand == `JLS_LOOP_ZERO) begin
              st_nxt.mode      = JLS_NOPREG;
              st_nxt.nop_kind  = JLS_NOP_ZERO;
              st_nxt.nop_depth = `JLS_DEPTH_ZERO;
            end else begin
              st_nxt.lp_cnt[st_r.depth]  = instr.operand - `JLS_OPND_ONE;
              st_nxt.lp_ret[st_r.depth]  = instr.addr + `JLS_ADDR_ONE;
              st_nxt.lp_task[st_r.depth] = instr.task_id;
              st_nxt.depth               = st_r.depth + `JLS_DEPTH_ONE;
            end
          end
          JLS_OP_LOOP_END: begin
            if (st_r.depth != `JLS_DEPTH_ZERO) begin
              if (st_r.lp_task[top] != instr.task_id ||
                  st_r.lp_cnt[top] == `JLS_LOOP_ZERO) begin
                st_nxt.depth = top;
              end else begin
                st_nxt.lp_cnt[top]  = st_r.lp_cnt[top] - `JLS_OPND_ONE;
                st_nxt.res.redirect = 1'b1;
                st_nxt.res.target   = st_r.lp_ret[top];
              end
            end
          end
          JLS_OP_LOOP_BREAK: begin
            st_nxt.flags = '0;
            if (st_r.depth != `JLS_DEPTH_ZERO && instr.cond) begin
              st_nxt.mode      = JLS_NOPREG;
              st_nxt.nop_kind  = JLS_NOP_BREAK;
              st_nxt.nop_depth = `JLS_DEPTH_ZERO;
            end
          end
          JLS_OP_RISING_EDGE_DETECT,
          JLS_OP_FALLING_EDGE_DETECT: begin
            if (st_r.ed_done[slot]) begin
              st_nxt.res.edge_q = st_r.ed_held[slot];
            end else begin
              // history only moves when executed, so a skip keeps it
              edge_now = (instr.op == JLS_OP_RISING_EDGE_DETECT)
                         ? (instr.cond && !st_r.ed_prev[slot])
                         : (!instr.cond && st_r.ed_prev[slot]);
              st_nxt.res.edge_q     = edge_now;
              st_nxt.ed_prev[slot]  = instr.cond;
              st_nxt.ed_held[slot]  = edge_now;
              st_nxt.ed_done[slot]  = (st_r.depth != `JLS_DEPTH_ZERO);
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st_r            <= '0;
      st_r.mode       <= JLS_RUN;
      // timer refresh never gated by skips
      st_r.timer_keep <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign res         = st_r.res;
  assign flags       = st_r.flags;
  assign overrun_err = st_r.overrun;
  assign timer_keep  = st_r.timer_keep;

endmodule

// ===== logic/jls_cfg.svh
`ifndef JLS_CFG_SVH
`define JLS_CFG_SVH

// widths
`define JLS_AW          12
`define JLS_NUM_W       7
`define JLS_OPND_W      16
`define JLS_TASK_W      4
`define JLS_DEPTH_W     4
`define JLS_EDGE_W      4
`define JLS_SCAN_W      32

// table sizes
`define JLS_MARKERS     128
`define JLS_LOOP_MAX    15
`define JLS_EDGE_SLOTS  16

// operand limits and one, zero and full constants
`define JLS_JNUM_MAX    16'h007f
`define JLS_LOOP_ZERO   16'h0000
`define JLS_OPND_ONE    16'h0001
`define JLS_ADDR_ONE    12'h001
`define JLS_DEPTH_ONE   4'h1
`define JLS_DEPTH_ZERO  4'h0
`define JLS_DEPTH_FULL  4'hf
`define JLS_SCAN_ONE    32'h00000001

// maximum scan time and its cycle count at the system clock rate
`define JLS_MAX_SCAN_MS 100
`define JLS_CLK_MHZ     100
`define JLS_MAX_SCAN_CYC (`JLS_MAX_SCAN_MS * 1000 * `JLS_CLK_MHZ)

`endif

// ===== logic/jls_pkg.sv
package jls_pkg;
  `include "jls_cfg.svh"

  typedef enum logic [3:0] {
    JLS_OP_OTHER             = 4'h0,
    JLS_OP_JUMP_ON_FALSE     = 4'h1,
    JLS_OP_JUMP_ON_TRUE      = 4'h2,
    JLS_OP_JUMP_END_MARKER   = 4'h3,
    JLS_OP_NOP_STYLE_JUMP    = 4'h4,
    JLS_OP_NOP_STYLE_JUMP_END = 4'h5,
    JLS_OP_LOOP_START        = 4'h6,
    JLS_OP_LOOP_END          = 4'h7,
    JLS_OP_LOOP_BREAK        = 4'h8,
    JLS_OP_RISING_EDGE_DETECT  = 4'h9,
    JLS_OP_FALLING_EDGE_DETECT = 4'ha
  } jls_op_e;

  typedef enum logic [1:0] {
    JLS_RUN    = 2'b01,
    JLS_NOPREG = 2'b10
  } jls_mode_e;

  typedef enum logic [1:0] {
    JLS_NOP_ZERO  = 2'h0,
    JLS_NOP_BREAK = 2'h1,
    JLS_NOP_NJ    = 2'h2
  } jls_nop_e;

  typedef struct packed {
    logic                    valid;
    jls_op_e                 op;
    logic [`JLS_OPND_W-1:0]  operand;
    logic                    cond;
    logic [`JLS_AW-1:0]      addr;
    logic [`JLS_TASK_W-1:0]  task_id;
  } jls_instr_s;

  typedef struct packed {
    logic                    valid;
    logic [`JLS_NUM_W-1:0]   num;
    logic [`JLS_AW-1:0]      addr;
  } jls_mark_s;

  typedef struct packed {
    logic                    valid;
    logic                    exec;
    logic                    no_operation;
    logic                    redirect;
    logic [`JLS_AW-1:0]      target;
    logic                    edge_q;
  } jls_res_s;

  typedef struct packed {
    logic error_flag;
    logic equals_flag;
    logic negative_flag;
  } jls_flags_s;

  typedef struct packed {
    jls_mode_e                                    mode;
    jls_nop_e                                     nop_kind;
    logic [`JLS_DEPTH_W-1:0]                      nop_depth;
    logic [`JLS_NUM_W-1:0]                        nop_num;
    logic [`JLS_DEPTH_W-1:0]                      depth;
    logic [`JLS_LOOP_MAX-1:0][`JLS_OPND_W-1:0]    lp_cnt;
    logic [`JLS_LOOP_MAX-1:0][`JLS_AW-1:0]        lp_ret;
    logic [`JLS_LOOP_MAX-1:0][`JLS_TASK_W-1:0]    lp_task;
    logic [`JLS_MARKERS-1:0]                      mk_valid;
    logic [`JLS_MARKERS-1:0][`JLS_AW-1:0]         mk_addr;
    logic [`JLS_EDGE_SLOTS-1:0]                   ed_prev;
    logic [`JLS_EDGE_SLOTS-1:0]                   ed_done;
    logic [`JLS_EDGE_SLOTS-1:0]                   ed_held;
    logic [`JLS_SCAN_W-1:0]                       scan_cnt;
    logic                                         overrun;
    logic                                         timer_keep;
    jls_flags_s                                   flags;
    jls_res_s                                     res;
  } jls_state_s;
endpackage

// ===== tb/jls_sequencer_chk.sv
`timescale 1ns/1ps
module jls_sequencer_chk
  import jls_pkg::*;
#(
  parameter int unsigned MAX_SCAN_CYC = 50
) (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       reset,
  // stimulus side
  input wire jls_instr_s instr,
  input wire logic       block_mode,
  input wire logic       scan_start,
  input wire logic       prog_end,
  input wire logic       mark_clr,
  input wire jls_mark_s  mark,
  // answers
  input wire jls_res_s   res,
  input wire jls_flags_s flags,
  input wire logic       overrun_err,
  input wire logic       timer_keep
);
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic        take;
  logic [31:0] scan_r;
  assign take = instr.valid && !scan_start;
  ////////////////////////////////////////////////////////////////////////
  // own scan count; small slack around the posedge on which the design raises overrun
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) scan_r <= 32'h0;
    else if (scan_start) scan_r <= 32'h0;
    else if (!prog_end && scan_r < 32'hffff) scan_r <= scan_r + 32'h1;
  end
  ////////////////////////////////////////////////////////////////////////
  answer_one_cycle_a: assert property (take |=> res.valid)
    else $error("no answer one cycle after an instruction");
  answer_cause_a: assert property (res.valid |-> $past(take))
    else $error("answer without an instruction");
  jump_range_a: assert property (
    take && (instr.op == JLS_OP_JUMP_ON_FALSE || instr.op == JLS_OP_JUMP_ON_TRUE)
    && instr.operand > 16'h007f |=> flags.error_flag && !res.redirect)
    else $error("bad jump number not flagged");
  marker_flags_a: assert property (
    take && instr.op == JLS_OP_JUMP_END_MARKER |=> $stable(flags))
    else $error("end marker changed flags");
  true_continue_a: assert property (
    take && instr.op == JLS_OP_JUMP_ON_FALSE && instr.cond && !block_mode
    |=> res.exec && !res.redirect)
    else $error("jump on false jumped with true condition");
  false_continue_a: assert property (
    take && instr.op == JLS_OP_JUMP_ON_TRUE && !instr.cond |=> !res.redirect)
    else $error("jump on true jumped with false condition");
  block_skip_a: assert property (
    take && instr.op == JLS_OP_JUMP_ON_FALSE && block_mode
    |=> res.redirect || flags.error_flag)
    else $error("block program did not skip");
  nest_flags_a: assert property (
    take && instr.op == JLS_OP_LOOP_START |=> !flags.equals_flag && !flags.negative_flag)
    else $error("loop start left equals or negative set");
  break_clear_a: assert property (
    take && instr.op == JLS_OP_LOOP_BREAK && instr.cond |=> flags == 3'h0)
    else $error("loop break left a flag set");
  overrun_hold_a: assert property (overrun_err |=> overrun_err)
    else $error("overrun error dropped");
  overrun_time_a: assert property (
    $rose(overrun_err) |-> scan_r + 32'h2 >= MAX_SCAN_CYC && scan_r <= MAX_SCAN_CYC + 2)
    else $error("overrun raised at wrong time");
  timer_keep_a: assert property (timer_keep)
    else $error("timer keep low");
endmodule

bind jls_sequencer jls_sequencer_chk #(.MAX_SCAN_CYC(MAX_SCAN_CYC)) u_chk (
  .sys_clk(sys_clk), .reset(reset), .instr(instr), .block_mode(block_mode),
  .scan_start(scan_start), .prog_end(prog_end), .mark_clr(mark_clr), .mark(mark),
  .res(res), .flags(flags), .overrun_err(overrun_err), .timer_keep(timer_keep));

// ===== tb/jls_tb.sv
`timescale 1ns/1ps
module testbench;
  import jls_pkg::*;
  logic       sys_clk;
  logic       reset;
  jls_instr_s instr;
  logic       block_mode;
  logic       scan_start;
  logic       prog_end;
  logic       mark_clr;
  jls_mark_s  mark;
  jls_res_s   res;
  jls_flags_s flags;
  logic       overrun_err;
  logic       timer_keep;
  int         n_fail;
  int         comparisons;
  int         cyc;
  localparam jls_op_e op_jf = JLS_OP_JUMP_ON_FALSE;
  localparam jls_op_e op_jt = JLS_OP_JUMP_ON_TRUE;
  localparam jls_op_e op_mk = JLS_OP_JUMP_END_MARKER;
  localparam jls_op_e op_ls = JLS_OP_LOOP_START;
  localparam jls_op_e op_le = JLS_OP_LOOP_END;
  localparam jls_op_e op_ot = JLS_OP_OTHER;

  jls_sequencer #(.MAX_SCAN_CYC(50)) u_dut (
    .sys_clk(sys_clk), .reset(reset), .instr(instr), .block_mode(block_mode),
    .scan_start(scan_start), .prog_end(prog_end), .mark_clr(mark_clr), .mark(mark),
    .res(res), .flags(flags), .overrun_err(overrun_err), .timer_keep(timer_keep));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // a run far past the planned two hundred or so cycles means a hang
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      print_verdict();
    end
  end

  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  // one instruction, then the answer cycle; keeps the two-cycle spacing
  task automatic issue(jls_op_e op, logic [15:0] n, logic c, logic [11:0] a,
                       logic [3:0] t = 4'h0);
    @(negedge sys_clk);
    instr = '{1'b1, op, n, c, a, t};
    @(negedge sys_clk);
    instr.valid = 1'b0;
    chk("answer", 16'h1, {15'h0, res.valid});
  endtask

  task automatic expect_jump(logic rd, logic [11:0] tg);
    chk("redirect", {15'h0, rd}, {15'h0, res.redirect});
    if (rd) chk("target", {4'h0, tg}, {4'h0, res.target});
  endtask

  task automatic body(logic np);
    chk("nop", {15'h0, np}, {15'h0, res.no_operation});
    chk("exec", {15'h0, !np}, {15'h0, res.exec});
  endtask

  task automatic err(logic e);
    chk("error", {15'h0, e}, {15'h0, flags.error_flag});
  endtask

  task automatic load(logic [6:0] n, logic [11:0] a);
    @(negedge sys_clk);
    mark = '{1'b1, n, a};
    @(negedge sys_clk);
    mark.valid = 1'b0;
  endtask

  task automatic new_scan();
    @(negedge sys_clk);
    scan_start = 1'b1;
    @(negedge sys_clk);
    scan_start = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_jumps();
    load(7'h05, 12'h020);
    load(7'h05, 12'h030);
    load(7'h06, 12'h040);
    load(7'h7f, 12'h050);
    issue(op_jf, 16'h0005, 1'b0, 12'h008);
    expect_jump(1'b1, 12'h020);
    err(1'b0);
    issue(op_mk, 16'h0005, 1'b0, 12'h020);
    issue(op_jf, 16'h0005, 1'b1, 12'h021);
    expect_jump(1'b0, 12'h000);
    issue(op_jt, 16'h0006, 1'b1, 12'h022);
    expect_jump(1'b1, 12'h040);
    issue(op_mk, 16'h0006, 1'b0, 12'h040);
    issue(op_jt, 16'h0006, 1'b0, 12'h041);
    expect_jump(1'b0, 12'h000);
    issue(op_jf, 16'h0080, 1'b0, 12'h042);
    err(1'b1);
    issue(op_mk, 16'h0005, 1'b0, 12'h043);
    err(1'b1);
    issue(op_jf, 16'h0009, 1'b0, 12'h044);
    err(1'b1);
    issue(op_jt, 16'h007f, 1'b0, 12'h045);
    err(1'b0);
    block_mode = 1'b1;
    issue(op_jf, 16'h0005, 1'b1, 12'h046);
    expect_jump(1'b1, 12'h020);
    issue(op_mk, 16'h0005, 1'b0, 12'h020);
    issue(op_jt, 16'h0006, 1'b0, 12'h021);
    expect_jump(1'b0, 12'h000);
    block_mode = 1'b0;
  endtask

  // no outward jumps, no step instructions
  task automatic t_loops();
    new_scan();
    issue(op_ls, 16'h0002, 1'b0, 12'h010);
    err(1'b0);
    issue(JLS_OP_RISING_EDGE_DETECT, 16'h0003, 1'b1, 12'h011);
    chk("edge", 16'h1, {15'h0, res.edge_q});
    issue(op_le, 16'h0000, 1'b0, 12'h012);
    expect_jump(1'b1, 12'h011);
    issue(JLS_OP_RISING_EDGE_DETECT, 16'h0003, 1'b0, 12'h011);
    chk("edge", 16'h1, {15'h0, res.edge_q});
    issue(op_le, 16'h0000, 1'b0, 12'h012);
    expect_jump(1'b0, 12'h000);
    issue(op_ls, 16'h0000, 1'b0, 12'h013);
    issue(op_ot, 16'h0000, 1'b0, 12'h014);
    body(1'b1);
    issue(op_le, 16'h0000, 1'b0, 12'h015);
    issue(op_ot, 16'h0000, 1'b0, 12'h016);
    body(1'b0);
    issue(op_ls, 16'h0003, 1'b0, 12'h017);
    issue(JLS_OP_LOOP_BREAK, 16'h0000, 1'b1, 12'h018);
    chk("flags", 16'h0, {13'h0, flags});
    issue(op_ot, 16'h0000, 1'b0, 12'h019);
    body(1'b1);
    issue(op_le, 16'h0000, 1'b0, 12'h01a);
    expect_jump(1'b0, 12'h000);
    issue(op_ls, 16'h0002, 1'b0, 12'h01b, 4'h1);
    issue(op_le, 16'h0000, 1'b0, 12'h01c, 4'h2);
    expect_jump(1'b0, 12'h000);
    new_scan();
    for (int i = 0; i < 15; i++) issue(op_ls, 16'h0001, 1'b0, 12'h100 + 12'(i));
    err(1'b0);
    issue(op_ls, 16'h0001, 1'b0, 12'h10f);
    err(1'b1);
    new_scan();
    issue(JLS_OP_NOP_STYLE_JUMP, 16'h0004, 1'b0, 12'h060);
    issue(op_ot, 16'h0000, 1'b0, 12'h061);
    body(1'b1);
    issue(JLS_OP_NOP_STYLE_JUMP_END, 16'h0004, 1'b0, 12'h062);
    issue(op_ot, 16'h0000, 1'b0, 12'h063);
    body(1'b0);
  endtask

  task automatic t_overrun();
    chk("keep", 16'h1, {15'h0, timer_keep});
    prog_end = 1'b0;
    new_scan();
    repeat (40) @(negedge sys_clk);
    chk("overrun", 16'h0, {15'h0, overrun_err});
    repeat (20) @(negedge sys_clk);
    chk("overrun", 16'h1, {15'h0, overrun_err});
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    n_fail = 0;
    comparisons = 0;
    cyc = 0;
    reset = 1'b1;
    instr = '0;
    mark = '0;
    block_mode = 1'b0;
    scan_start = 1'b0;
    prog_end = 1'b1;
    mark_clr = 1'b0;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    reset = 1'b0;
    t_jumps();
    t_loops();
    t_overrun();
    print_verdict();
  end
endmodule
